/* File: logic/sar_adc_serial_readout.sv */
`timescale 1ns/1ps
module sar_adc_serial_readout (
   // system clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   // serial link pins
   input wire logic i_sck,
   input wire logic i_convert_strobe,
   input wire logic i_select_input,
   output logic o_result_out,
   output logic o_result_oe_n,
   // analog front end
   input wire logic i_comp_high,
   output logic o_sample_switch,
   output logic [sar_adc_pkg::RES_W-1:0] o_dac_code
);
   import sar_adc_pkg::*;

   localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYC - 1);
   localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYC - 1);
   localparam logic [CNT_W-1:0] POS_DATA = CNT_W'(RES_W);
   localparam int A_CONV_CYC = CONV_CYC;

   logic rstn_s;
   logic strobe_s;
   logic sel_s;
   logic sck_s;
   logic clr_r, clr_nxt;
   logic [CNT_W-1:0] sck_cnt_r, sck_cnt_nxt;
   logic [CNT_W-1:0] sck_gray_r, sck_gray_nxt;
   logic [RES_W-1:0] chain_buf_r, chain_buf_nxt;
   logic [CNT_W-1:0] gray_s;
   logic [RES_W-1:0] chain_s;
   logic [CNT_W-1:0] link_pos;
   conv_state_t state_r, state_nxt;
   logic strobe_d_r, strobe_d_nxt;
   logic sel_d_r, sel_d_nxt;
   logic mode_cs_r, mode_cs_nxt;
   logic chain_busy_r, chain_busy_nxt;
   logic busy_r, busy_nxt;
   logic [RES_W-1:0] sar_r, sar_nxt;
   logic [RES_W-1:0] mask_r, mask_nxt;
   logic [RES_W-1:0] dac_r, dac_nxt;
   logic [RES_W-1:0] result_r, result_nxt;
   logic [CONV_CNT_W-1:0] conv_cnt_r, conv_cnt_nxt;
   logic [STEP_W-1:0] step_r, step_nxt;
   logic switch_r, switch_nxt;
   logic out_r, out_nxt;
   logic oe_n_r, oe_n_nxt;
   logic strobe_rise;
   logic cs_n;
   logic in_conv;
   logic [CNT_W-1:0] dpos;

   // reset release and pin synchronisers
   bit_sync #(.W(1)) rst_sync (
      .i_clock(i_clock),
      .i_rstn(i_rstn),
      .i_d(1'b1),
      .o_q(rstn_s)
   );

   bit_sync #(.W(3)) pin_sync (
      .i_clock(i_clock),
      .i_rstn(rstn_s),
      .i_d({i_convert_strobe, i_select_input, i_sck}),
      .o_q({strobe_s, sel_s, sck_s})
   );

   // link side: falling-edge counter and upstream capture on the serial clock
   always_comb begin
      sck_cnt_nxt = sck_cnt_r;
      if (sck_cnt_r != '1) begin
         sck_cnt_nxt = sck_cnt_r + CNT_W'(1);
      end
      sck_gray_nxt = sck_cnt_nxt ^ (sck_cnt_nxt >> 1);
      chain_buf_nxt = chain_buf_r;
      chain_buf_nxt[sck_cnt_r[IDX_W-1:0]] = i_select_input;
   end

   // cleared by the frame signal from the system side; the link clock may stop
   always_ff @(negedge i_sck or posedge clr_r) begin
      if (clr_r) begin
         sck_cnt_r <= '0;
         sck_gray_r <= '0;
         chain_buf_r <= '0;
      end else begin
         sck_cnt_r <= sck_cnt_nxt;
         sck_gray_r <= sck_gray_nxt;
         chain_buf_r <= chain_buf_nxt;
      end
   end

   // gray count and quasi-static upstream bits cross into the system domain
   bit_sync #(.W(CNT_W + RES_W)) link_sync (
      .i_clock(i_clock),
      .i_rstn(rstn_s),
      .i_d({sck_gray_r, chain_buf_r}),
      .o_q({gray_s, chain_s})
   );

   // gray to binary position: each bit is the parity of the gray bits at and above it
   genvar gi;
   generate
      for (gi = 0; gi < CNT_W; gi = gi + 1) begin : g_gray
         assign link_pos[gi] = ^(gray_s >> gi);
      end
   endgenerate

   // select is low whenever either line is low: 3-wire or 4-wire
   assign cs_n = strobe_s & sel_s;
   assign strobe_rise = strobe_s & ~strobe_d_r;
   assign in_conv = (state_r == ST_CONV);
   assign dpos = link_pos - {{(CNT_W-1){1'b0}}, busy_r};

   // conversion sequencer, successive approximation and result capture
   always_comb begin
      logic [RES_W-1:0] kept;
      kept = sar_r;
      state_nxt = state_r;
      strobe_d_nxt = strobe_s;
      sel_d_nxt = sel_s;
      mode_cs_nxt = mode_cs_r;
      chain_busy_nxt = chain_busy_r;
      busy_nxt = busy_r;
      sar_nxt = sar_r;
      mask_nxt = mask_r;
      dac_nxt = dac_r;
      result_nxt = result_r;
      conv_cnt_nxt = conv_cnt_r;
      step_nxt = step_r;
      switch_nxt = switch_r;
      unique case (state_r)
         ST_ACQ, ST_DONE: begin
            if (strobe_rise) begin
               state_nxt = ST_CONV;
               // level before the edge, so a select tied to the strobe reads low
               mode_cs_nxt = sel_d_r;
               chain_busy_nxt = sck_s;
               switch_nxt = 1'b0;
               sar_nxt = CODE_ZERO;
               mask_nxt = MSB_MASK;
               dac_nxt = MSB_MASK;
               conv_cnt_nxt = '0;
               step_nxt = '0;
            end
         end
         ST_CONV: begin
            // strobe level is ignored until the count runs out
            conv_cnt_nxt = conv_cnt_r + CONV_CNT_W'(1);
            step_nxt = step_r + STEP_W'(1);
            if (step_r == STEP_LAST) begin
               step_nxt = '0;
               if (mask_r != CODE_ZERO) begin
                  kept = i_comp_high ? dac_r : sar_r;
                  sar_nxt = kept;
                  mask_nxt = mask_r >> 1;
                  dac_nxt = kept | (mask_r >> 1);
               end
            end
            if (conv_cnt_r == CONV_LAST) begin
               state_nxt = ST_DONE;
               result_nxt = sar_r;
               switch_nxt = 1'b1;
               dac_nxt = CODE_ZERO;
               busy_nxt = mode_cs_r ? ~cs_n : chain_busy_r;
            end
         end
      endcase
   end

   // readout: pin drive follows mode, position and select
   always_comb begin
      clr_nxt = 1'b1;
      oe_n_nxt = OE_OFF_N;
      out_nxt = 1'b0;
      if (!mode_cs_r) begin
         oe_n_nxt = OE_DRIVE_N;
         if (state_r == ST_DONE) begin
            clr_nxt = 1'b0;
            if (busy_r && link_pos == '0) begin
               out_nxt = sel_s;
            end else if (dpos < POS_DATA) begin
               out_nxt = result_r[RES_W - 1 - int'(dpos[IDX_W-1:0])];
            end else begin
               out_nxt = chain_s[dpos[IDX_W-1:0]];
            end
         end
      end else if (state_r == ST_DONE && !cs_n) begin
         clr_nxt = 1'b0;
         if (link_pos < POS_DATA + {{(CNT_W-1){1'b0}}, busy_r}) begin
            oe_n_nxt = OE_DRIVE_N;
            if (busy_r && link_pos == '0) begin
               out_nxt = BUSY_LVL;
            end else begin
               out_nxt = result_r[RES_W - 1 - int'(dpos[IDX_W-1:0])];
            end
         end
      end
   end

   // system-domain registers
   always_ff @(posedge i_clock or negedge rstn_s) begin
      if (!rstn_s) begin
         state_r <= ST_ACQ;
         strobe_d_r <= 1'b0;
         sel_d_r <= 1'b0;
         mode_cs_r <= 1'b1;
         chain_busy_r <= 1'b0;
         busy_r <= 1'b0;
         sar_r <= CODE_ZERO;
         mask_r <= CODE_ZERO;
         dac_r <= CODE_ZERO;
         result_r <= CODE_ZERO;
         conv_cnt_r <= '0;
         step_r <= '0;
         switch_r <= 1'b1;
         clr_r <= 1'b1;
         out_r <= 1'b0;
         oe_n_r <= OE_OFF_N;
      end else begin
         state_r <= state_nxt;
         strobe_d_r <= strobe_d_nxt;
         sel_d_r <= sel_d_nxt;
         mode_cs_r <= mode_cs_nxt;
         chain_busy_r <= chain_busy_nxt;
         busy_r <= busy_nxt;
         sar_r <= sar_nxt;
         mask_r <= mask_nxt;
         dac_r <= dac_nxt;
         result_r <= result_nxt;
         conv_cnt_r <= conv_cnt_nxt;
         step_r <= step_nxt;
         switch_r <= switch_nxt;
         clr_r <= clr_nxt;
         out_r <= out_nxt;
         oe_n_r <= oe_n_nxt;
      end
   end

   assign o_result_out = out_r;
   assign o_result_oe_n = oe_n_r;
   assign o_sample_switch = switch_r;
   assign o_dac_code = dac_r;

   // checks on the conversion sequencer
   a_switch_open_conv: assert property (@(posedge i_clock) disable iff (!rstn_s)
      in_conv |-> !o_sample_switch)
      else $error("input switch closed during conversion");

   a_switch_reconnect: assert property (@(posedge i_clock) disable iff (!rstn_s)
      $rose(state_r == ST_DONE) |-> o_sample_switch && !$past(o_sample_switch))
      else $error("input switch not reconnected at conversion end");

   a_conv_length: assert property (@(posedge i_clock) disable iff (!rstn_s)
      $rose(in_conv) |-> ##[A_CONV_CYC:A_CONV_CYC] (state_r == ST_DONE))
      else $error("conversion length wrong");

   a_sar_step: assert property (@(posedge i_clock) disable iff (!rstn_s)
      (in_conv && step_r == STEP_LAST && mask_r != CODE_ZERO)
      |=> sar_r == ($past(i_comp_high) ? $past(dac_r) : $past(sar_r)))
      else $error("approximation step kept wrong code");

   a_result_now: assert property (@(posedge i_clock) disable iff (!rstn_s)
      $rose(state_r == ST_DONE) |-> result_r == $past(sar_r))
      else $error("result not taken at conversion end");

   a_mode_latch: assert property (@(posedge i_clock) disable iff (!rstn_s)
      (strobe_rise && !in_conv) |=> mode_cs_r == $past(sel_d_r))
      else $error("mode not latched at strobe rise");

   a_mode_hold: assert property (@(posedge i_clock) disable iff (!rstn_s)
      (in_conv && $past(in_conv)) |-> $stable(mode_cs_r))
      else $error("mode changed during conversion");

   // checks on the readout pin
   a_cs_msb_first: assert property (@(posedge i_clock) disable iff (!rstn_s)
      (mode_cs_r && state_r == ST_DONE && !busy_r && !cs_n && link_pos == '0 && !strobe_rise)
      |=> !o_result_oe_n && o_result_out == result_r[RES_W-1])
      else $error("msb not driven on select");

   a_cs_release: assert property (@(posedge i_clock) disable iff (!rstn_s)
      (mode_cs_r && cs_n) |=> o_result_oe_n)
      else $error("pin driven while deselected");

   a_count_release: assert property (@(posedge i_clock) disable iff (!rstn_s)
      (mode_cs_r && link_pos >= POS_DATA + {{(CNT_W-1){1'b0}}, busy_r})
      |=> o_result_oe_n)
      else $error("pin driven after last bit");

   a_daisy_busy: assert property (@(posedge i_clock) disable iff (!rstn_s)
      (!mode_cs_r && state_r == ST_DONE && busy_r && link_pos == '0 && sel_s && !strobe_rise)
      |=> o_result_out && !o_result_oe_n)
      else $error("daisy busy not driven high");

endmodule // sar_adc_serial_readout

/* File: pkg/sar_adc_pkg.sv */
package sar_adc_pkg;

   // data path widths
   localparam int RES_W = 16;
   localparam int IDX_W = 4;
   localparam int CNT_W = 8;

   // timing, in ns as printed, and the cycle counts derived from them
   localparam int CLK_PERIOD_NS = 20;
   localparam int CONV_MIN_NS = 772;
   localparam int CONV_TYP_NS = 812;
   localparam int CONV_MAX_NS = 853;
   // cycles from a pin edge to the state change, plus the output flop
   localparam int SYNC_LAT = 3;
   // longest time rounds down; the pin synchroniser eats part of it
   localparam int CONV_CYC = CONV_MAX_NS / CLK_PERIOD_NS - SYNC_LAT;
   // one trial bit per step; all steps fit inside the conversion window
   localparam int STEP_CYC = CONV_CYC / RES_W;
   localparam int STEP_W = 2;
   localparam int CONV_CNT_W = 6;

   // codes and levels
   localparam logic [RES_W-1:0] MSB_MASK = 16'h8000;
   localparam logic [RES_W-1:0] CODE_ZERO = 16'h0000;
   localparam logic BUSY_LVL = 1'b0;
   localparam logic OE_DRIVE_N = 1'b0;
   localparam logic OE_OFF_N = 1'b1;

   // conversion sequencer
   typedef enum logic [2:0] {
      ST_ACQ = 3'b001,
      ST_CONV = 3'b010,
      ST_DONE = 3'b100
   } conv_state_t;

endpackage

/* File: logic/bit_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser, one pair per bit
module bit_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   // data
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);

   logic [W-1:0] meta_r;

   // first stage feeds only the second stage
   genvar gi;
   generate
      for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
         always_ff @(posedge i_clock or negedge i_rstn) begin
            if (!i_rstn) begin
               meta_r[gi] <= 1'b0;
               o_q[gi] <= 1'b0;
            end else begin
               meta_r[gi] <= i_d[gi];
               o_q[gi] <= meta_r[gi];
            end
         end
      end
   endgenerate

endmodule // bit_sync

/* File: bench/adc_host_model.sv */
`timescale 1ns/1ps
// serial host: makes the link clock only inside frames
module adc_host_model (
   // resolved data wire
   input wire logic i_data,
   // link clock
   output logic o_sck
);
   logic base_clk;

   // 32 ns base clock, phase unrelated to the system clock
   initial base_clk = 1'b0;
   initial o_sck = 1'b0;
   always #16 base_clk = ~base_clk;

   // shift n bits msb first; sample while low, one falling edge per bit
   task automatic shift(input int n, output logic [31:0] bits);
      bits = '0;
      for (int i = 0; i < n; i++) begin
         repeat (4) @(posedge base_clk);
         bits = {bits[30:0], i_data};
         o_sck <= 1'b1;
         repeat (4) @(posedge base_clk);
         o_sck <= 1'b0;
      end
   endtask

   // clock level held across a strobe rise picks the daisy busy bit
   task automatic park(input logic lvl);
      @(posedge base_clk);
      o_sck <= lvl;
   endtask
endmodule // adc_host_model

/* File: bench/sar_adc_serial_readout_bench.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module sar_adc_serial_readout_bench;
   import sar_adc_pkg::*;
   logic clock, rstn, strobe, sel, comp, dout, oe_n, sw, dout_w, sck;
   logic [RES_W-1:0] vin, dac;
   int err_total = 0;
   int compares = 0;

   // clock and an ideal comparator; the data wire has a pull-up
   initial clock = 1'b0;
   always #10 clock = ~clock;
   assign comp = (vin >= dac);
   assign dout_w = (oe_n === OE_DRIVE_N) ? dout : 1'b1;

   sar_adc_serial_readout i_dut (
      .i_clock(clock), .i_rstn(rstn), .i_sck(sck), .i_convert_strobe(strobe),
      .i_select_input(sel), .o_result_out(dout), .o_result_oe_n(oe_n),
      .i_comp_high(comp), .o_sample_switch(sw), .o_dac_code(dac)
   );
   adc_host_model host (.i_data(dout_w), .o_sck(sck));

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // back to idle levels between tests
   task automatic idle();
      @(posedge clock);
      strobe <= 1'b0;
      sel <= 1'b1;
      repeat (4) @(posedge clock);
   endtask

   // one conversion; bz drops the strobe at cycles 10 and 30 with a stray rise at 20
   task automatic convert(input logic [15:0] v, input logic s, input logic tie,
                          input logic bz);
      int n;
      logic low;
      n = 0;
      low = 1'b0;
      @(posedge clock);
      vin <= v;
      sel <= s;
      repeat (2) @(posedge clock);
      strobe <= 1'b1;
      if (tie) sel <= 1'b1;
      while (n < 60 && !(low && sw === 1'b1)) begin
         @(posedge clock);
         n++;
         if (bz && (n == 10 || n == 30)) strobe <= 1'b0;
         if (bz && n == 20) strobe <= 1'b1;
         #1;
         if (sw === 1'b0) low = 1'b1;
      end
      if (n >= 60) begin
         err_total++;
         tally_and_finish();
      end
      `CHK(n * CLK_PERIOD_NS >= CONV_MIN_NS && n * CLK_PERIOD_NS <= CONV_MAX_NS, 1'b1)
   endtask

   // chip select without busy, 4-wire and 3-wire in turn, landmark codes, release after 16 bits
   task automatic t_cs4();
      logic [31:0] b;
      logic [15:0] codes [4] = '{16'h0000, 16'h8000, 16'h7fff, 16'hffff};
      foreach (codes[k]) begin
         convert(codes[k], 1'b1, 1'b0, 1'b0);
         @(posedge clock);
         if (k[0]) strobe <= 1'b0;
         else sel <= 1'b0;
         repeat (6) @(posedge clock);
         #1;
         `CHK({oe_n, dout_w}, {OE_DRIVE_N, codes[k][15]})
         host.shift(16, b);
         `CHK(b[15:0], codes[k])
         repeat (6) @(posedge clock);
         #1;
         `CHK(oe_n, OE_OFF_N)
         idle();
      end
      $display("test cs4 done");
   endtask

   // 3-wire with busy bit, stray strobe rise during conversion
   task automatic t_cs3b();
      logic [31:0] b;
      convert(16'ha5c3, 1'b1, 1'b0, 1'b1);
      repeat (4) @(posedge clock);
      #1;
      `CHK({oe_n, dout_w}, {OE_DRIVE_N, BUSY_LVL})
      host.shift(17, b);
      `CHK(b[16:0], {BUSY_LVL, 16'ha5c3})
      repeat (6) @(posedge clock);
      #1;
      `CHK(oe_n, OE_OFF_N)
      idle();
      $display("test cs3 busy done");
   endtask

   // deselect in mid readout releases the wire
   task automatic t_abort();
      logic [31:0] b;
      convert(16'h5a3c, 1'b1, 1'b0, 1'b0);
      @(posedge clock);
      sel <= 1'b0;
      repeat (6) @(posedge clock);
      host.shift(4, b);
      `CHK(b[3:0], 4'h5)
      @(posedge clock);
      sel <= 1'b1;
      repeat (6) @(posedge clock);
      #1;
      `CHK(oe_n, OE_OFF_N)
      idle();
      $display("test abort done");
   endtask

   // select tied to strobe: daisy chain, upstream ones follow the data
   task automatic t_daisy();
      logic [31:0] b;
      host.park(1'b0);
      convert(16'h3c96, 1'b0, 1'b1, 1'b0);
      repeat (4) @(posedge clock);
      #1;
      `CHK(oe_n, OE_DRIVE_N)
      host.shift(32, b);
      `CHK(b, {16'h3c96, 16'hffff})
      idle();
      $display("test daisy done");
   endtask

   // daisy chain with busy: clock high at the strobe rise
   task automatic t_daisyb();
      logic [31:0] b;
      host.park(1'b1);
      convert(16'h0f0f, 1'b0, 1'b0, 1'b0);
      repeat (2) @(posedge clock);
      sel <= 1'b1;
      repeat (6) @(posedge clock);
      #1;
      `CHK({oe_n, dout_w}, {OE_DRIVE_N, 1'b1})
      host.shift(17, b);
      `CHK(b[16:0], {1'b1, 16'h0f0f})
      idle();
      $display("test daisy busy done");
   endtask

   // main sequence
   initial begin
      rstn = 1'b0;
      strobe = 1'b0;
      sel = 1'b1;
      vin = '0;
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      repeat (6) @(posedge clock);
      #1;
      `CHK({oe_n, sw, dac}, {OE_OFF_N, 1'b1, CODE_ZERO})
      t_cs4();
      t_cs3b();
      t_abort();
      t_daisy();
      t_daisyb();
      tally_and_finish();
   end
endmodule // sar_adc_serial_readout_bench
